// file: logic/rcf_pkg.sv
// Purpose: Shared constants, types and register map of the freq_slope_stage stage logic.
// Assumes: 200 MHz aclk, freq_slope_stage in 0.001 Hz/s, frequency in 0.01 Hz, time in 5 ms steps.
// Notes: Cycle counts derive from the printed times and the clock period.
package rcf_pkg;
	localparam int NSTG        = 8;
	localparam int CLK_NS      = 5;
	localparam int TS_RES_MS   = 1;
	localparam int PROG_CYC_MS = 5;
	localparam int PRE_TRIG_MS = 20;
	localparam int MS_CYC      = TS_RES_MS * 1000000 / CLK_NS;
	localparam int PROG_CYC    = PROG_CYC_MS * 1000000 / CLK_NS;
	localparam int PRE_DEPTH   = PRE_TRIG_MS / PROG_CYC_MS;
	localparam int REC_DEPTH   = 12;
	localparam int NEVT        = 48;

	// Release hysteresis of 100 mHz/s in 0.001 Hz/s units.
	localparam logic [15:0] HYST        = 16'h0064;
	// One unit of the readout ratio is 0.005 p.u., so the ratio is scaled by 200.
	localparam logic [23:0] RATIO_SCALE = 24'h0000c8;
	localparam logic [7:0]  EVT_TAG     = 8'h01;
	localparam logic [5:0]  EV_BLK_BASE = 6'h20;

	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_SW_BLK   = 8'h04;
	localparam logic [7:0] A_MASK_ON  = 8'h08;
	localparam logic [7:0] A_MASK_OFF = 8'h0c;
	localparam logic [7:0] A_STATUS   = 8'h10;
	localparam logic [7:0] A_MEAS     = 8'h14;
	localparam logic [7:0] A_STG_SEL  = 8'h18;
	localparam logic [7:0] A_OP_TIME  = 8'h1c;
	localparam logic [7:0] A_PICKUP   = 8'h20;
	localparam logic [7:0] A_REMAIN   = 8'h24;
	localparam logic [7:0] A_EXPECT   = 8'h28;
	localparam logic [7:0] A_RATIO    = 8'h2c;
	localparam logic [7:0] A_REC_SEL  = 8'h30;
	localparam logic [7:0] A_REC_TIME = 8'h34;
	localparam logic [7:0] A_REC_INFO = 8'h38;
	localparam logic [7:0] A_REC_PRE  = 8'h3c;
	localparam logic [7:0] A_REC_FLT  = 8'h40;
	localparam logic [7:0] A_REC_PTR  = 8'h44;

	localparam logic [23:0] MASK_RST = 24'hffffff;
	localparam logic [18:0] OPT_RST  = 19'h00014;
	localparam logic [13:0] PICK_RST = 14'h00c8;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;

	typedef enum logic [1:0] {ST_NORM, ST_START, ST_TRIP, ST_BLK} rcf_st_e;

	typedef struct packed {
		logic [7:0]  tag;
		logic [5:0]  code;
		logic [31:0] stamp;
		logic [15:0] dfdt;
		logic [15:0] freq;
	} rcf_evt_s;

	typedef struct packed {
		logic [31:0] stamp;
		logic [5:0]  code;
		logic [2:0]  sg;
		logic [15:0] pre_dfdt;
		logic [15:0] pre_freq;
		logic [15:0] flt_dfdt;
		logic [15:0] flt_freq;
	} rcf_rec_s;
endpackage

// file: logic/rcf_stage_block.sv
// Purpose: Blocking, status, event and fault-record logic of eight freq_slope_stage stages.
// Assumes: Measurements come from logic on aclk; block pins are asynchronous.
// Notes: Registers are reached over AXI4-Lite.
// Summary of operation
// RULE1 - Trip follows start after fixed definite delay.
// RULE2 - Block input sampled at each program cycle start.
// RULE3 - Pick-up unblocked asserts start, starts delay timer.
// RULE4 - Pick-up while blocked asserts blocked, nothing more.
// RULE5 - Block during start drops start, releases timer.
// RULE6 - Blocking gives display note and snapshot event.
// RULE7 - Partner asserts block 5 ms before delay ends.
// RULE8 - Test forcing lets software switch drive block.
// RULE9 - Stage code: normal, started, tripped, blocked.
// RULE10 - Expose signed remaining time to trip.
// RULE11 - Expose expected operating time of fault.
// RULE12 - Expose present measured freq_slope_stage continuously.
// RULE13 - Expose per-stage freq_slope_stage to pick-up ratio.
// RULE14 - Each output change raises ON or OFF event.
// RULE15 - Mask selects ON, OFF or both events.
// RULE16 - Events carry time stamp and process data.
// RULE17 - One block tag, forty-eight event codes.
// RULE18 - Circular store keeps twelve most recent records.
// RULE19 - Record holds time, event, pre-trig, fault, group.
// RULE20 - Time stamps count whole milliseconds.
// RULE21 - Instant mode emits start and trip together.
// RULE22 - Pick-up releases 100 mHz/s below setting.
// RULE23 - Timer steps per cycle while started, clears otherwise.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
module rcf_stage_block
	import rcf_pkg::*;
#(
	parameter int MS_CYCLES   = MS_CYC,
	parameter int PROG_CYCLES = PROG_CYC
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Blocking matrix pins and measurements
	input  wire logic [7:0]  block_in,
	input  wire logic [15:0] meas_dfdt,
	input  wire logic [15:0] meas_freq,
	input  wire logic [2:0]  settings_group,
	// Stage outputs
	output logic [7:0]       start_o,
	output logic [7:0]       trip_o,
	output logic [7:0]       blocked_o,
	output logic             hmi_note,
	// Event buffer port
	output logic             evt_valid,
	input  wire logic        evt_ready,
	output rcf_evt_s         evt_data
);

	function automatic logic [31:0] wr32(logic [31:0] old, logic [31:0] d, logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] ratio_calc(logic [15:0] m, logic [13:0] p);
		logic [23:0] q;
		q = 24'h0;
		if (p != 14'h0) begin
			q = ({8'h0, m} * RATIO_SCALE) / {10'h0, p};
		end
		return ((p == 14'h0) || (q > 24'h00ffff)) ? 16'hffff : q[15:0];
	endfunction

	function automatic logic [5:0] first_set(logic [NEVT-1:0] v);
		logic [5:0] r;
		r = 6'h0;
		for (int k = NEVT - 1; k >= 0; k--) begin
			if (v[k]) begin
				r = 6'(k);
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] st_code(rcf_st_e s);
		logic [1:0] c;
		unique case (s)
			ST_NORM:  c = 2'h0;
			ST_START: c = 2'h1;
			ST_TRIP:  c = 2'h2;
			ST_BLK:   c = 2'h3;
		endcase
		return c;
	endfunction

	logic [19:0]      prog_cnt_ff;
	logic [17:0]      ms_cnt_ff;
	logic [31:0]      ms_ff;
	logic             tick_ff;
	logic             eval_ff;
	logic             chk_ff;
	logic [7:0]       s1_ff;
	logic [7:0]       s2_ff;
	logic [7:0]       s3_ff;
	logic [7:0]       bsync_ff;
	logic [7:0]       blk_ff;
	logic [7:0]       pick_ff;
	logic [31:0]      su_ff [NSTG];
	logic [31:0]      hist_ff [PRE_DEPTH];
	rcf_st_e          st_ff [NSTG];
	logic [18:0]      tmr_ff [NSTG];
	logic [7:0]       prv_st_ff;
	logic [7:0]       prv_tr_ff;
	logic [7:0]       prv_bl_ff;
	logic [NEVT-1:0]  pend_ff;
	logic [NEVT-1:0]  pset;
	logic [NEVT-1:0]  pclr;
	logic             ld;
	logic [5:0]       ecode;
	logic [2:0]       estg;
	logic [31:0]      stamp_ff;
	rcf_rec_s         rec_ff [REC_DEPTH];
	logic [3:0]       rec_wp_ff;
	logic [3:0]       rec_cnt_ff;
	logic             force_ff;
	logic [7:0]       sw_blk_ff;
	logic [23:0]      mask_on_ff;
	logic [23:0]      mask_off_ff;
	logic [2:0]       sel_ff;
	logic [3:0]       rsel_ff;
	logic [18:0]      op_ff [NSTG];
	logic [13:0]      pu_ff [NSTG];
	logic [7:0]       aw_ff;
	logic             awv_ff;
	logic [31:0]      wd_ff;
	logic [3:0]       ws_ff;
	logic             wv_ff;
	logic [31:0]      rd_val;
	logic             rd_ok;
	logic             wr_ok;
	logic [31:0]      wr_old;
	logic [31:0]      wmrg;
	logic [19:0]      remain;
	rcf_rec_s         rrec;

	// Program cycle and millisecond time base.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_cnt_ff <= 20'h0;
			tick_ff     <= 1'b0;
			eval_ff     <= 1'b0;
			chk_ff      <= 1'b0;
		end else begin
			tick_ff     <= (prog_cnt_ff == 20'(PROG_CYCLES - 1));
			prog_cnt_ff <= (prog_cnt_ff == 20'(PROG_CYCLES - 1)) ? 20'h0 : prog_cnt_ff + 20'h1;
			eval_ff     <= tick_ff;
			chk_ff      <= eval_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ms_cnt_ff <= 18'h0;
			ms_ff     <= 32'h0;
		end else if (ms_cnt_ff == 18'(MS_CYCLES - 1)) begin
			ms_cnt_ff <= 18'h0;
			ms_ff     <= ms_ff + 32'h1; // [RULE20]
		end else begin
			ms_cnt_ff <= ms_cnt_ff + 18'h1;
		end
	end

	// A pin change counts once the second and third stages agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff    <= 8'h0;
			s2_ff    <= 8'h0;
			s3_ff    <= 8'h0;
			bsync_ff <= 8'h0;
		end else begin
			s1_ff <= block_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				bsync_ff <= s3_ff;
			end
		end
	end

	// Block and pick-up are both frozen at the tick, one clock before the stages evaluate.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blk_ff  <= 8'h0;
			pick_ff <= 8'h0;
			for (int i = 0; i < NSTG; i++) begin
				su_ff[i] <= 32'h0;
			end
			for (int j = 0; j < PRE_DEPTH; j++) begin
				hist_ff[j] <= 32'h0;
			end
		end else if (tick_ff) begin
			blk_ff <= force_ff ? sw_blk_ff : bsync_ff; // [RULE2] [RULE8]
			hist_ff[0] <= {meas_dfdt, meas_freq};
			for (int j = 1; j < PRE_DEPTH; j++) begin
				hist_ff[j] <= hist_ff[j-1];
			end
			for (int i = 0; i < NSTG; i++) begin
				if (pick_ff[i]) begin
					pick_ff[i] <= ({1'b0, meas_dfdt} + {1'b0, HYST}) >= {3'h0, pu_ff[i]}; // [RULE22]
				end else if (meas_dfdt >= {2'h0, pu_ff[i]}) begin
					pick_ff[i] <= 1'b1;
					su_ff[i]   <= {meas_dfdt, meas_freq}; // [RULE6]
				end
			end
		end
	end

	// Stage state; a zero delay trips in the same cycle as the start.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NSTG; i++) begin
				st_ff[i]  <= ST_NORM;
				tmr_ff[i] <= 19'h0;
			end
		end else if (eval_ff) begin
			for (int i = 0; i < NSTG; i++) begin
				tmr_ff[i] <= 19'h0; // [RULE23]
				if (!pick_ff[i]) begin
					st_ff[i] <= ST_NORM;
				end else if (blk_ff[i]) begin
					st_ff[i] <= ST_BLK; // [RULE4] [RULE5]
				end else begin
					unique case (st_ff[i])
						ST_NORM, ST_BLK: begin
							st_ff[i] <= (op_ff[i] == 19'h0) ? ST_TRIP : ST_START; // [RULE3] [RULE21]
						end
						ST_START: begin
							if (tmr_ff[i] + 19'h1 >= op_ff[i]) begin
								st_ff[i] <= ST_TRIP; // [RULE1]
							end else begin
								tmr_ff[i] <= tmr_ff[i] + 19'h1; // [RULE23]
							end
						end
						ST_TRIP: st_ff[i] <= ST_TRIP;
					endcase
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NSTG; i++) begin
			start_o[i]   = (st_ff[i] == ST_START) || (st_ff[i] == ST_TRIP);
			trip_o[i]    = (st_ff[i] == ST_TRIP);
			blocked_o[i] = (st_ff[i] == ST_BLK);
		end
	end

	// Edge detection into masked pending events.
	always_comb begin
		pset = '0;
		if (chk_ff) begin
			for (int i = 0; i < NSTG; i++) begin
				pset[i*4]     = start_o[i] & ~prv_st_ff[i] & mask_on_ff[i*3]; // [RULE14] [RULE15]
				pset[i*4 + 1] = ~start_o[i] & prv_st_ff[i] & mask_off_ff[i*3];
				pset[i*4 + 2] = trip_o[i] & ~prv_tr_ff[i] & mask_on_ff[i*3 + 1];
				pset[i*4 + 3] = ~trip_o[i] & prv_tr_ff[i] & mask_off_ff[i*3 + 1];
				pset[32 + i*2] = blocked_o[i] & ~prv_bl_ff[i] & mask_on_ff[i*3 + 2];
				pset[33 + i*2] = ~blocked_o[i] & prv_bl_ff[i] & mask_off_ff[i*3 + 2];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prv_st_ff <= 8'h0;
			prv_tr_ff <= 8'h0;
			prv_bl_ff <= 8'h0;
			stamp_ff  <= 32'h0;
			hmi_note  <= 1'b0;
		end else begin
			hmi_note <= chk_ff && |(blocked_o & ~prv_bl_ff); // [RULE6]
			if (chk_ff) begin
				prv_st_ff <= start_o;
				prv_tr_ff <= trip_o;
				prv_bl_ff <= blocked_o;
				stamp_ff  <= ms_ff; // [RULE21]
			end
		end
	end

	// One event leaves per clock while the buffer accepts; lowest code first.
	assign ld    = (|pend_ff) && (!evt_valid || evt_ready);
	assign ecode = first_set(pend_ff);
	assign estg  = ecode[5] ? ecode[3:1] : ecode[4:2];
	assign pclr  = ld ? (NEVT'(1) << ecode) : '0;

	// A new event wins over the clear of the same bit.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= (pend_ff & ~pclr) | pset;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_valid <= 1'b0;
			evt_data  <= '0;
		end else if (ld) begin
			evt_valid      <= 1'b1;
			evt_data.tag   <= EVT_TAG; // [RULE17]
			evt_data.code  <= ecode;
			evt_data.stamp <= stamp_ff; // [RULE16]
			evt_data.dfdt  <= ecode[5] ? su_ff[estg][31:16] : meas_dfdt;
			evt_data.freq  <= ecode[5] ? su_ff[estg][15:0] : meas_freq;
		end else if (evt_ready) begin
			evt_valid <= 1'b0;
		end
	end

	// Start ON and trip ON events enter the circular record store.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rec_wp_ff  <= 4'h0;
			rec_cnt_ff <= 4'h0;
		end else if (ld && !ecode[5] && !ecode[0]) begin
			rec_ff[rec_wp_ff] <= '{stamp_ff, ecode, settings_group, hist_ff[PRE_DEPTH-1][31:16],
				hist_ff[PRE_DEPTH-1][15:0], meas_dfdt, meas_freq}; // [RULE19]
			rec_wp_ff <= (rec_wp_ff == 4'(REC_DEPTH - 1)) ? 4'h0 : rec_wp_ff + 4'h1; // [RULE18]
			if (rec_cnt_ff != 4'(REC_DEPTH)) begin
				rec_cnt_ff <= rec_cnt_ff + 4'h1;
			end
		end
	end

	// AXI4-Lite write side: address and data are taken in either order.
	assign awready = !awv_ff && !bvalid;
	assign wready  = !wv_ff && !bvalid;

	// The old contents are merged under the byte strobes before any field is cut out.
	always_comb begin
		wr_old = 32'h0;
		wr_ok  = 1'b1;
		unique case (aw_ff & 8'hfc)
			A_CTRL:     wr_old = {31'h0, force_ff};
			A_SW_BLK:   wr_old = {24'h0, sw_blk_ff};
			A_MASK_ON:  wr_old = {8'h0, mask_on_ff};
			A_MASK_OFF: wr_old = {8'h0, mask_off_ff};
			A_STG_SEL:  wr_old = {29'h0, sel_ff};
			A_OP_TIME:  wr_old = {13'h0, op_ff[sel_ff]};
			A_PICKUP:   wr_old = {18'h0, pu_ff[sel_ff]};
			A_REC_SEL:  wr_old = {28'h0, rsel_ff};
			default:    wr_ok = 1'b0;
		endcase
	end

	assign wmrg = wr32(wr_old, wd_ff, ws_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awv_ff <= 1'b0;
			wv_ff  <= 1'b0;
			aw_ff  <= 8'h0;
			wd_ff  <= 32'h0;
			ws_ff  <= 4'h0;
			bvalid <= 1'b0;
			bresp  <= RESP_OK;
		end else begin
			if (awvalid && awready) begin
				awv_ff <= 1'b1;
				aw_ff  <= awaddr;
			end
			if (wvalid && wready) begin
				wv_ff <= 1'b1;
				wd_ff <= wdata;
				ws_ff <= wstrb;
			end
			if (awv_ff && wv_ff) begin
				awv_ff <= 1'b0;
				wv_ff  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= wr_ok ? RESP_OK : RESP_ERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_ff    <= 1'b0;
			sw_blk_ff   <= 8'h0;
			mask_on_ff  <= MASK_RST;
			mask_off_ff <= MASK_RST;
			sel_ff      <= 3'h0;
			rsel_ff     <= 4'h0;
			for (int i = 0; i < NSTG; i++) begin
				op_ff[i] <= OPT_RST;
				pu_ff[i] <= PICK_RST;
			end
		end else if (awv_ff && wv_ff) begin
			unique case (aw_ff & 8'hfc)
				A_CTRL:     force_ff <= wmrg[0];
				A_SW_BLK:   sw_blk_ff <= wmrg[7:0];
				A_MASK_ON:  mask_on_ff <= wmrg[23:0];
				A_MASK_OFF: mask_off_ff <= wmrg[23:0];
				A_STG_SEL:  sel_ff <= wmrg[2:0];
				A_OP_TIME:  op_ff[sel_ff] <= wmrg[18:0];
				A_PICKUP:   pu_ff[sel_ff] <= wmrg[13:0];
				A_REC_SEL:  rsel_ff <= wmrg[3:0];
				default: ;
			endcase
		end
	end

	// AXI4-Lite read side: data are registered one clock after the address.
	assign arready = !rvalid;
	assign remain  = {1'b0, op_ff[sel_ff]} - {1'b0, tmr_ff[sel_ff]};
	assign rrec    = rec_ff[rsel_ff];

	always_comb begin
		rd_val = 32'h0;
		rd_ok  = 1'b1;
		unique case (araddr & 8'hfc)
			A_CTRL:     rd_val = {31'h0, force_ff};
			A_SW_BLK:   rd_val = {24'h0, sw_blk_ff};
			A_MASK_ON:  rd_val = {8'h0, mask_on_ff};
			A_MASK_OFF: rd_val = {8'h0, mask_off_ff};
			A_STATUS: begin
				for (int i = 0; i < NSTG; i++) begin
					rd_val[i*2 +: 2] = st_code(st_ff[i]); // [RULE9]
				end
			end
			A_MEAS:     rd_val = {16'h0, meas_dfdt}; // [RULE12]
			A_STG_SEL:  rd_val = {29'h0, sel_ff};
			A_OP_TIME:  rd_val = {13'h0, op_ff[sel_ff]};
			A_PICKUP:   rd_val = {18'h0, pu_ff[sel_ff]};
			A_REMAIN:   rd_val = {{12{remain[19]}}, remain}; // [RULE10]
			A_EXPECT:   rd_val = {13'h0, op_ff[sel_ff]}; // [RULE11]
			A_RATIO:    rd_val = {16'h0, ratio_calc(meas_dfdt, pu_ff[sel_ff])}; // [RULE13]
			A_REC_SEL:  rd_val = {28'h0, rsel_ff};
			A_REC_TIME: rd_val = (rsel_ff < rec_cnt_ff) ? rrec.stamp : 32'h0;
			A_REC_INFO: rd_val = (rsel_ff < rec_cnt_ff) ? {23'h0, rrec.sg, rrec.code} : 32'h0;
			A_REC_PRE:  rd_val = (rsel_ff < rec_cnt_ff) ? {rrec.pre_dfdt, rrec.pre_freq} : 32'h0;
			A_REC_FLT:  rd_val = (rsel_ff < rec_cnt_ff) ? {rrec.flt_dfdt, rrec.flt_freq} : 32'h0;
			A_REC_PTR:  rd_val = {24'h0, rec_cnt_ff, rec_wp_ff};
			default:    rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= RESP_OK;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_val;
			rresp  <= rd_ok ? RESP_OK : RESP_ERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule

// file: verif/rcf_stage_block_sva.sv
// Purpose: Port-level checks of the freq_slope_stage stage block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to every instance of the stage block.
module rcf_stage_block_sva
	import rcf_pkg::*;
#(
	parameter int MS_CYCLES   = MS_CYC,
	parameter int PROG_CYCLES = PROG_CYC
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        awready,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// Stage outputs and events
	input wire logic [7:0]  start_o,
	input wire logic [7:0]  trip_o,
	input wire logic [7:0]  blocked_o,
	input wire logic        hmi_note,
	input wire logic        evt_valid,
	input wire logic        evt_ready,
	input wire rcf_evt_s    evt_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] outs;
	assign outs = {start_o, trip_o, blocked_o};
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_blk_rise;
		(blocked_o & ~$past(blocked_o)) != 8'h00;
	endsequence
	a_blk_excl: assert property (((start_o | trip_o) & blocked_o) == 8'h00)
		else $error("blocked stage also shows start or trip");
	// Outputs move only at the evaluation edge of a program cycle.
	a_out_hold: assert property ($changed(outs) |=> $stable(outs)[*8])
		else $error("stage outputs changed twice in one program cycle");
	a_evt_hold: assert property (evt_valid && !evt_ready |=> evt_valid && $stable(evt_data))
		else $error("event dropped or altered before acceptance");
	a_evt_tag: assert property (evt_valid |-> evt_data.tag == EVT_TAG)
		else $error("event block tag wrong");
	a_evt_code: assert property (evt_valid |-> evt_data.code < 6'h30)
		else $error("event code out of range");
	a_hmi_blk: assert property (s_blk_rise |-> ##[0:2] hmi_note)
		else $error("no display note on blocking");
	a_hmi_pulse: assert property (hmi_note |=> !hmi_note)
		else $error("display note longer than one cycle");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
		else $error("read response not held");
	a_b_gate: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
endmodule

bind rcf_stage_block rcf_stage_block_sva #(.MS_CYCLES(MS_CYCLES), .PROG_CYCLES(PROG_CYCLES))
	u_rcf_stage_block_sva (.aclk(aclk), .aresetn(aresetn), .awready(awready),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .start_o(start_o), .trip_o(trip_o),
	.blocked_o(blocked_o), .hmi_note(hmi_note), .evt_valid(evt_valid),
	.evt_ready(evt_ready), .evt_data(evt_data));

// file: verif/rcf_partner_model.sv
// Purpose: Blocking matrix and event buffer beside the stage block.
// Assumes: The bench decides when each stage is blocked.
// Notes: Slow mode accepts an event only every other clock.
module rcf_partner_model
	import rcf_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Bench control
	input  wire logic [7:0] blk_req,
	input  wire logic       slow,
	input  wire logic       clr,
	// Stage block side
	output logic [7:0]      block_in,
	input  wire logic       evt_valid,
	output logic            evt_ready,
	input  wire rcf_evt_s   evt_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [47:0] seen;
	logic [31:0] stp [48];
	logic [15:0] dfv [48];
	// Blocking is raised far ahead of any trip deadline, never within the last 5 ms.
	always_ff @(posedge aclk) block_in <= blk_req;
	always_ff @(posedge aclk) evt_ready <= !aresetn || !slow || !evt_ready;
	always_ff @(posedge aclk) begin
		if (clr) begin
			seen <= 48'h0;
		end else if (evt_valid && evt_ready) begin
			seen[evt_data.code] <= 1'b1;
			stp[evt_data.code] <= evt_data.stamp;
			dfv[evt_data.code] <= evt_data.dfdt;
		end
	end
endmodule

// file: verif/rcf_stage_block_tb.sv
// Purpose: Self-checking bench of the freq_slope_stage stage block.
// Assumes: Short program cycle of 200 clocks and 10-clock milliseconds.
// Notes: Stages 1 to 7 get a high pick-up so only chosen stages act.
module rcf_stage_block_tb
	import rcf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 200;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, clr;
	logic        awready, wready, bvalid, arready, rvalid, hmi_note, evt_valid, evt_ready;
	logic [7:0]  awaddr, araddr, block_in, blk_req, start_o, trip_o, blocked_o;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [15:0] meas_dfdt, meas_freq;
	logic [2:0]  settings_group;
	rcf_evt_s    evt_data;
	int          errors, comparisons;
	time         t0;

	always #2.5 aclk = ~aclk;

	rcf_stage_block #(.MS_CYCLES(10), .PROG_CYCLES(P)) u_rcf_stage_block (.aclk, .aresetn,
		.awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.block_in, .meas_dfdt, .meas_freq, .settings_group, .start_o, .trip_o,
		.blocked_o, .hmi_note, .evt_valid, .evt_ready, .evt_data);

	rcf_partner_model u_rcf_partner_model (.aclk, .aresetn, .blk_req, .slow, .clr,
		.block_in, .evt_valid, .evt_ready, .evt_data);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(negedge aclk); while (!(awready && wready));
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(negedge aclk); while (!bvalid);
		// A late bready lets the response-hold check see a stalled answer.
		@(posedge aclk);
		bready <= 1'b1;
		@(negedge aclk);
		chk({30'h0, bresp}, {30'h0, er});
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OK);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		@(posedge aclk);
		rready <= 1'b1;
		@(negedge aclk);
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Waits for one stage output of kind k to reach level v, then lands on a rising edge.
	task automatic wt(input int k, input int s, input logic v);
		int i = 0;
		while (((k == 0) ? start_o[s] : (k == 1) ? trip_o[s] : blocked_o[s]) !== v && i < 9000) begin
			@(negedge aclk);
			i++;
		end
		if (i == 9000) chk(32'h0, 32'h1);
		@(posedge aclk);
	endtask

	task automatic clear();
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
	endtask

	task automatic t_regs();
		rd(A_STATUS, 32'h0);
		rd(A_MASK_ON, {8'h00, MASK_RST});
		rd(A_EXPECT, {13'h0, OPT_RST});
		rd(8'h80, 32'h0, RESP_ERR);
		wr(8'h80, 32'h1, RESP_ERR);
		for (int s = 1; s < 8; s++) begin
			wr(A_STG_SEL, 32'(s));
			wr(A_PICKUP, 32'h3fff);
		end
		$display("test regs done");
	endtask

	task automatic t_trip();
		wr(A_STG_SEL, 32'h0);
		wr(A_OP_TIME, 32'h3);
		clear();
		meas_dfdt <= 16'h0190;
		wt(0, 0, 1'b1);
		t0 = $time;
		rd(A_STATUS, 32'h1);
		rd(A_REMAIN, 32'h3);
		rd(A_EXPECT, 32'h3);
		rd(A_MEAS, 32'h190);
		rd(A_RATIO, 32'h190);
		wt(1, 0, 1'b1);
		chk(32'(($time - t0) / 5), 32'(3 * P));
		rd(A_STATUS, 32'h2);
		repeat (20) @(posedge aclk);
		chk({30'h0, u_rcf_partner_model.seen[2], u_rcf_partner_model.seen[0]}, 32'h3);
		chk(u_rcf_partner_model.stp[2] - u_rcf_partner_model.stp[0], 32'h3c);
		rd(A_REC_PTR, 32'h22);
		wr(A_REC_SEL, 32'h1);
		rd(A_REC_INFO, 32'h142);
		rd(A_REC_FLT, 32'h01901388);
		rd(A_REC_PRE, 32'h01901388);
		$display("test trip done");
	endtask

	task automatic t_block();
		meas_dfdt <= 16'h0000;
		wt(1, 0, 1'b0);
		wr(A_OP_TIME, 32'h14);
		meas_dfdt <= 16'h0190;
		wt(0, 0, 1'b1);
		clear();
		slow <= 1'b1;
		meas_dfdt <= 16'h01f4;
		blk_req <= 8'h01;
		wt(2, 0, 1'b1);
		chk({30'h0, start_o[0], trip_o[0]}, 32'h0);
		rd(A_REMAIN, 32'h14);
		rd(A_STATUS, 32'h3);
		repeat (40) @(posedge aclk);
		chk({30'h0, u_rcf_partner_model.seen[32], u_rcf_partner_model.seen[1]}, 32'h3);
		chk({16'h0, u_rcf_partner_model.dfv[32]}, 32'h190);
		blk_req <= 8'h00;
		wt(0, 0, 1'b1);
		meas_dfdt <= 16'h0000;
		slow <= 1'b0;
		wt(0, 0, 1'b0);
		$display("test block done");
	endtask

	task automatic t_force();
		wr(A_CTRL, 32'h1);
		wr(A_SW_BLK, 32'h2);
		blk_req <= 8'h01;
		wr(A_STG_SEL, 32'h1);
		wr(A_PICKUP, 32'hc8);
		meas_dfdt <= 16'h0190;
		wt(2, 1, 1'b1);
		wt(0, 0, 1'b1);
		chk({24'h0, blocked_o}, 32'h2);
		rd(A_STATUS, 32'hd);
		meas_dfdt <= 16'h0000;
		blk_req <= 8'h00;
		wr(A_CTRL, 32'h0);
		wr(A_PICKUP, 32'h3fff);
		wt(0, 0, 1'b0);
		$display("test force done");
	endtask

	task automatic t_mask();
		wr(A_STG_SEL, 32'h0);
		wr(A_OP_TIME, 32'h0);
		wr(A_MASK_ON, 32'h3);
		wr(A_MASK_OFF, 32'h0);
		clear();
		meas_dfdt <= 16'h0190;
		wt(1, 0, 1'b1);
		repeat (20) @(posedge aclk);
		meas_dfdt <= 16'h006e;
		repeat (P + 20) @(posedge aclk);
		chk({31'h0, trip_o[0]}, 32'h1);
		meas_dfdt <= 16'h0000;
		wt(1, 0, 1'b0);
		repeat (20) @(posedge aclk);
		chk({28'h0, u_rcf_partner_model.seen[3:0]}, 32'h5);
		chk(u_rcf_partner_model.stp[0], u_rcf_partner_model.stp[2]);
		$display("test mask done");
	endtask

	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, clr} = 9'h0;
		{awaddr, araddr, blk_req, wdata} = 56'h0;
		{meas_dfdt, meas_freq, settings_group} = {16'h0000, 16'h1388, 3'h5};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_trip();
		t_block();
		t_force();
		t_mask();
		conclude();
	end

	// Whole run needs some 15 us; a hang is cut off well beyond that.
	initial begin
		#200us;
		errors++;
		conclude();
	end
endmodule
